/* File: hdl/pmcc_top.sv */
/*
  Clock control: system PLL and USB PLL control with settle counters,
  master clock select, prescale and processor-to-bus ratio, processor
  idle gating, USB and memory clock gating, all behind an APB slave.
  Assumes every clock source arrives as a one-cycle tick synchronous to
  ref_clk, and that the analog PLL macros take the ratio, multiplier and
  enable outputs and return their output as ticks.
*/
`timescale 1ns/100ps

module pmcc_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        low_freq_tick,
  input  wire logic        base_osc_tick,
  input  wire logic        system_pll_tick,
  input  wire logic        usb_pll_tick,
  input  wire logic        instr_done,
  input  wire logic        wake_irq,
  output logic [7:0]       system_pll_input_ratio,
  output logic [10:0]      system_pll_multiplier,
  output logic             system_pll_enable,
  output logic             usb_pll_enable,
  output logic [5:0]       usb_pll_factor,
  output logic             system_pll_out,
  output logic             cpu_clock_tick,
  output logic             bus_clock,
  output logic             ddr_clock_tick,
  output logic             usb_dev_clock_tick,
  output logic             usb_host_clock_tick,
  output logic             ohci_48m_clock,
  output logic             ohci_12m_clock,
  output logic             clock_irq
);

  logic [31:0]     sclk_q;
  logic [31:0]     pclk_q;
  logic [31:0]     spll_q;
  logic [31:0]     upll_q;
  logic [31:0]     mclk_q;
  logic [31:0]     fs_q;
  logic [2:0]      irq_mask_q;
  logic [5:0]      spll_cnt_q;
  logic [3:0]      upll_cnt_q;
  logic [2:0]      slow8_q;
  logic            spll_settled_q;
  logic            upll_settled_q;
  logic            switch_done_q;
  logic            halve_q;
  logic [5:0]      pre_cnt_q;
  logic [1:0]      bus_cnt_q;
  logic [3:0]      fs_cnt_q;
  logic [1:0]      fs12_cnt_q;
  logic            cpu_on;
  pmcc_pkg::pmcc_cpu_state_t cpu_q;

  logic        wr;
  logic        rd;
  logic        hit;
  logic [7:0]  new_ratio;
  logic [10:0] new_mul;
  logic        spll_run;
  logic        spll_gated;
  logic        spll_used;
  logic        src_tick;
  logic [5:0]  pre_lim;
  logic        pre_tick;
  logic [1:0]  bus_lim;
  logic        bus_tick;
  logic        fs_src;
  logic        fs_tick;
  logic        upll_step;

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped offsets.
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    case (paddr)
      pmcc_pkg::OFF_SCLK_EN,  pmcc_pkg::OFF_SCLK_DIS, pmcc_pkg::OFF_SCLK_ST,
      pmcc_pkg::OFF_PCLK_EN,  pmcc_pkg::OFF_PCLK_DIS, pmcc_pkg::OFF_PCLK_ST,
      pmcc_pkg::OFF_UPLL_CFG, pmcc_pkg::OFF_SPLL_CFG, pmcc_pkg::OFF_MCLK_CFG,
      pmcc_pkg::OFF_FS_CFG,   pmcc_pkg::OFF_STATUS,   pmcc_pkg::OFF_IRQ_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from flip-flops.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      case (paddr)
        pmcc_pkg::OFF_SCLK_ST:  prdata <= {sclk_q[31:1], cpu_on};
        pmcc_pkg::OFF_PCLK_ST:  prdata <= pclk_q;
        pmcc_pkg::OFF_UPLL_CFG: prdata <= upll_q;
        pmcc_pkg::OFF_SPLL_CFG: prdata <= spll_q;
        pmcc_pkg::OFF_MCLK_CFG: prdata <= mclk_q;
        pmcc_pkg::OFF_FS_CFG:   prdata <= fs_q;
        pmcc_pkg::OFF_IRQ_MASK: prdata <= {29'h0000_0000, irq_mask_q};
        pmcc_pkg::OFF_STATUS: begin
          prdata <= 32'h0000_0000;
          prdata[pmcc_pkg::ST_SPLL_BIT]   <= spll_settled_q;
          prdata[pmcc_pkg::ST_SWITCH_BIT] <= switch_done_q;
          prdata[pmcc_pkg::ST_UPLL_BIT]   <= upll_settled_q;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Configuration registers.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= pmcc_pkg::SCLK_RST;
      pclk_q <= 32'h0000_0000;
    end else if (wr) begin
      case (paddr)
        pmcc_pkg::OFF_SCLK_EN:  sclk_q <= sclk_q | pwdata;
        pmcc_pkg::OFF_SCLK_DIS: sclk_q <= sclk_q & ~pwdata;
        pmcc_pkg::OFF_PCLK_EN:  pclk_q <= pclk_q | pwdata;
        pmcc_pkg::OFF_PCLK_DIS: pclk_q <= pclk_q & ~pwdata;
        default: sclk_q <= sclk_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      spll_q     <= 32'h0000_0000;
      upll_q     <= 32'h0000_0000;
      mclk_q     <= pmcc_pkg::MCLK_RST;
      fs_q       <= pmcc_pkg::FS_RST;
      irq_mask_q <= 3'h0;
    end else if (wr) begin
      case (paddr)
        pmcc_pkg::OFF_SPLL_CFG: spll_q <= pwdata;
        pmcc_pkg::OFF_UPLL_CFG: upll_q <= pwdata;
        pmcc_pkg::OFF_MCLK_CFG: mclk_q <= pwdata;
        pmcc_pkg::OFF_FS_CFG:   fs_q <= pwdata;
        pmcc_pkg::OFF_IRQ_MASK: irq_mask_q <= pwdata[2:0];
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // ==========================================================================
  // System PLL control and settle counter.
  assign system_pll_input_ratio = spll_q[pmcc_pkg::SPLL_RATIO_LSB +: 8];
  assign system_pll_multiplier  = spll_q[pmcc_pkg::SPLL_MUL_LSB +: 11];
  assign system_pll_enable      = (system_pll_multiplier != 11'h000);
  assign new_ratio = pwdata[pmcc_pkg::SPLL_RATIO_LSB +: 8];
  assign new_mul   = pwdata[pmcc_pkg::SPLL_MUL_LSB +: 11];
  assign spll_run  = system_pll_enable & (system_pll_input_ratio != 8'h00);

  // A write that enables the PLL or alters ratio or multiplier restarts
  // the count; a write that only touches the settle field does not.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      spll_cnt_q     <= 6'h00;
      spll_settled_q <= 1'b0;
    end else if (wr && paddr == pmcc_pkg::OFF_SPLL_CFG && (new_mul == 11'h000)) begin
      spll_settled_q <= 1'b0;
    end else if (wr && paddr == pmcc_pkg::OFF_SPLL_CFG &&
                 (new_mul != system_pll_multiplier || new_ratio != system_pll_input_ratio)) begin
      spll_settled_q <= 1'b0;
      spll_cnt_q     <= pwdata[pmcc_pkg::SPLL_SETTLE_LSB +: 6];
    end else if (system_pll_enable && !spll_settled_q) begin
      if (spll_cnt_q == 6'h00) begin
        spll_settled_q <= 1'b1;
      end else if (low_freq_tick) begin
        spll_cnt_q <= spll_cnt_q - 6'h01;
      end
    end
  end

  // ==========================================================================
  // USB PLL control and settle counter on slow clock divided by 8.
  assign usb_pll_enable = upll_q[pmcc_pkg::UPLL_ON_BIT];
  assign usb_pll_factor = pmcc_pkg::UPLL_FACTOR;
  assign upll_step = low_freq_tick && (slow8_q == pmcc_pkg::SLOW_PER_UPLL_STEP);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      slow8_q <= 3'h0;
    end else if (low_freq_tick) begin
      slow8_q <= slow8_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      upll_cnt_q     <= 4'h0;
      upll_settled_q <= 1'b0;
    end else if (wr && paddr == pmcc_pkg::OFF_UPLL_CFG) begin
      upll_settled_q <= 1'b0;
      upll_cnt_q     <= pwdata[pmcc_pkg::UPLL_SETTLE_LSB +: 4];
    end else if (usb_pll_enable && !upll_settled_q) begin
      if (upll_cnt_q == 4'h0) begin
        upll_settled_q <= 1'b1;
      end else if (upll_step) begin
        upll_cnt_q <= upll_cnt_q - 4'h1;
      end
    end
  end

  // ==========================================================================
  // System PLL output gating and halving.
  assign spll_gated = system_pll_tick & spll_run;
  assign spll_used  = mclk_q[pmcc_pkg::MCLK_HALVE_BIT] ? (spll_gated & halve_q) : spll_gated;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      halve_q        <= 1'b0;
      system_pll_out <= 1'b0;
    end else begin
      if (spll_gated) begin
        halve_q <= ~halve_q;
      end
      system_pll_out <= spll_used;
    end
  end

  // ==========================================================================
  // Master clock source select, prescaler and bus ratio divider.
  always_comb begin
    case (mclk_q[pmcc_pkg::MCLK_SRC_LSB +: 2])
      pmcc_pkg::SRC_SLOW: src_tick = low_freq_tick;
      pmcc_pkg::SRC_BASE: src_tick = base_osc_tick;
      pmcc_pkg::SRC_SPLL: src_tick = spll_used;
      pmcc_pkg::SRC_UPLL: src_tick = usb_pll_tick & usb_pll_enable;
      default:            src_tick = 1'b0;
    endcase
  end

  // The prescaler limit is the divide value minus one.
  always_comb begin
    if (mclk_q[pmcc_pkg::MCLK_SCALE_LSB +: 3] == pmcc_pkg::SCALE_BY6) begin
      pre_lim = 6'h05;
    end else begin
      pre_lim = 6'((7'h01 << mclk_q[pmcc_pkg::MCLK_SCALE_LSB +: 3]) - 7'h01);
    end
  end

  assign pre_tick = src_tick && (pre_cnt_q >= pre_lim);
  assign bus_lim  = mclk_q[pmcc_pkg::MCLK_RATIO_LSB +: 2];
  assign bus_tick = pre_tick && (bus_cnt_q >= bus_lim);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_q <= 6'h00;
    end else if (pre_tick) begin
      pre_cnt_q <= 6'h00;
    end else if (src_tick) begin
      pre_cnt_q <= pre_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_cnt_q <= 2'h0;
    end else if (bus_tick) begin
      bus_cnt_q <= 2'h0;
    end else if (pre_tick) begin
      bus_cnt_q <= bus_cnt_q + 2'h1;
    end
  end

  // Done is set by the first bus tick of the new setting; a tick in the
  // write cycle itself still belongs to the old setting, so the clear wins.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_done_q <= 1'b1;
    end else if (wr && paddr == pmcc_pkg::OFF_MCLK_CFG) begin
      switch_done_q <= 1'b0;
    end else if (bus_tick) begin
      switch_done_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Processor clock idle gating. Bus clock keeps running for other masters.
  assign cpu_on = (cpu_q != pmcc_pkg::CPU_STOPPED);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_q <= pmcc_pkg::CPU_RUN;
    end else begin
      case (cpu_q)
        pmcc_pkg::CPU_RUN: begin
          if (wr && paddr == pmcc_pkg::OFF_SCLK_DIS && pwdata[pmcc_pkg::BIT_CPU_CLK]) begin
            cpu_q <= pmcc_pkg::CPU_DRAIN;
          end
        end
        pmcc_pkg::CPU_DRAIN: begin
          if (wake_irq) begin
            cpu_q <= pmcc_pkg::CPU_RUN;
          end else if (instr_done) begin
            cpu_q <= pmcc_pkg::CPU_STOPPED;
          end
        end
        pmcc_pkg::CPU_STOPPED: begin
          if (wake_irq) begin
            cpu_q <= pmcc_pkg::CPU_RUN;
          end
        end
        default: cpu_q <= pmcc_pkg::CPU_RUN;
      endcase
    end
  end

  // ==========================================================================
  // Full-speed host clock source and divider.
  assign fs_src  = fs_q[pmcc_pkg::FS_SRC_BIT] ? (usb_pll_tick & usb_pll_enable) : spll_used;
  assign fs_tick = fs_src && (fs_cnt_q >= fs_q[pmcc_pkg::FS_RATIO_LSB +: 4]);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fs_cnt_q   <= 4'h0;
      fs12_cnt_q <= 2'h0;
    end else begin
      if (fs_tick) begin
        fs_cnt_q   <= 4'h0;
        fs12_cnt_q <= fs12_cnt_q + 2'h1;
      end else if (fs_src) begin
        fs_cnt_q <= fs_cnt_q + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Clock outputs, gated except bus_clock, and interrupt.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_clock_tick      <= 1'b0;
      bus_clock           <= 1'b0;
      ddr_clock_tick      <= 1'b0;
      usb_dev_clock_tick  <= 1'b0;
      usb_host_clock_tick <= 1'b0;
      ohci_48m_clock      <= 1'b0;
      ohci_12m_clock      <= 1'b0;
      clock_irq           <= 1'b0;
    end else begin
      cpu_clock_tick <= pre_tick & cpu_on;
      bus_clock      <= bus_tick;
      ddr_clock_tick <= pre_tick & sclk_q[pmcc_pkg::BIT_MEM_CLK] & (bus_lim != 2'h0);
      usb_dev_clock_tick  <= usb_pll_tick & usb_pll_enable & pclk_q[pmcc_pkg::PID_USB_DEV];
      usb_host_clock_tick <= usb_pll_tick & usb_pll_enable & pclk_q[pmcc_pkg::PID_USB_HOST];
      ohci_48m_clock <= fs_tick & sclk_q[pmcc_pkg::BIT_OHCI_CLK];
      ohci_12m_clock <= fs_tick & (fs12_cnt_q == pmcc_pkg::OHCI_12M_DIV) &
                        sclk_q[pmcc_pkg::BIT_OHCI_CLK];
      clock_irq <= (irq_mask_q[0] & spll_settled_q) | (irq_mask_q[1] & switch_done_q) |
                   (irq_mask_q[2] & upll_settled_q);
    end
  end

endmodule

/* File: hdl/pmcc_pkg.sv */
/*
  Constants shared by the clock control block: register byte offsets,
  field positions, reset values and the processor clock state type.
  Assumes a 32-bit APB register bus with one register per aligned word.
*/
package pmcc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_SCLK_EN   = 8'h00;
  localparam logic [7:0] OFF_SCLK_DIS  = 8'h04;
  localparam logic [7:0] OFF_SCLK_ST   = 8'h08;
  localparam logic [7:0] OFF_PCLK_EN   = 8'h10;
  localparam logic [7:0] OFF_PCLK_DIS  = 8'h14;
  localparam logic [7:0] OFF_PCLK_ST   = 8'h18;
  localparam logic [7:0] OFF_UPLL_CFG  = 8'h1C;
  localparam logic [7:0] OFF_SPLL_CFG  = 8'h28;
  localparam logic [7:0] OFF_MCLK_CFG  = 8'h30;
  localparam logic [7:0] OFF_FS_CFG    = 8'h38;
  localparam logic [7:0] OFF_STATUS    = 8'h68;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h6C;

  // ==========================================================================
  // System clock bits
  localparam int BIT_CPU_CLK  = 0;
  localparam int BIT_MEM_CLK  = 2;
  localparam int BIT_OHCI_CLK = 6;

  // Peripheral ids of the high-speed USB device and host.
  localparam int PID_USB_DEV  = 23;
  localparam int PID_USB_HOST = 22;

  // ==========================================================================
  // Field positions
  localparam int SPLL_RATIO_LSB  = 0;
  localparam int SPLL_SETTLE_LSB = 8;
  localparam int SPLL_MUL_LSB    = 16;
  localparam int UPLL_ON_BIT     = 16;
  localparam int UPLL_SETTLE_LSB = 20;
  localparam int MCLK_SRC_LSB    = 0;
  localparam int MCLK_SCALE_LSB  = 4;
  localparam int MCLK_RATIO_LSB  = 8;
  localparam int MCLK_HALVE_BIT  = 12;
  localparam int FS_SRC_BIT      = 0;
  localparam int FS_RATIO_LSB    = 8;
  localparam int ST_SPLL_BIT     = 1;
  localparam int ST_SWITCH_BIT   = 3;
  localparam int ST_UPLL_BIT     = 6;

  // ==========================================================================
  // Encodings, factors and reset values
  localparam logic [1:0] SRC_SLOW = 2'h0;
  localparam logic [1:0] SRC_BASE = 2'h1;
  localparam logic [1:0] SRC_SPLL = 2'h2;
  localparam logic [1:0] SRC_UPLL = 2'h3;
  localparam logic [2:0] SCALE_BY6 = 3'h7;
  localparam logic [5:0] UPLL_FACTOR = 6'h28;
  localparam logic [2:0] SLOW_PER_UPLL_STEP = 3'h7;
  localparam logic [1:0] OHCI_12M_DIV = 2'h3;
  localparam logic [31:0] SCLK_RST = 32'h0000_0001;
  localparam logic [31:0] MCLK_RST = 32'h0000_0001;
  localparam logic [31:0] FS_RST   = 32'h0000_0000;

  typedef enum logic [2:0] {
    CPU_RUN     = 3'b001,
    CPU_DRAIN   = 3'b010,
    CPU_STOPPED = 3'b100
  } pmcc_cpu_state_t;

endpackage

/* File: verification/pmcc_checker.sv */
/*
  Checker for the clock control block: APB answer and gating of the PLL
  and USB clock outputs. Assumes it is bound to pmcc_top.
*/
`timescale 1ns/100ps

module pmcc_checker (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        system_pll_tick,
  input wire logic        usb_pll_tick,
  input wire logic [7:0]  system_pll_input_ratio,
  input wire logic [10:0] system_pll_multiplier,
  input wire logic        system_pll_enable,
  input wire logic [5:0]  usb_pll_factor,
  input wire logic        system_pll_out,
  input wire logic        usb_dev_clock_tick,
  input wire logic        usb_host_clock_tick
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_access;
    psel && penable;
  endsequence

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (s_access ##0 (paddr == 8'h0C) |-> pslverr)
    else $error("no error on unmapped access");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  a_ratio_zero: assert property (system_pll_input_ratio == 8'h00 |=> !system_pll_out)
    else $error("pll output with zero ratio");
  a_pll_cause: assert property (system_pll_out |-> $past(system_pll_tick) && $past(system_pll_enable))
    else $error("pll output without cause");
  a_mul_enable: assert property (system_pll_enable == (system_pll_multiplier != 11'h000))
    else $error("pll enable disagrees with multiplier");
  a_usb_factor: assert property (usb_pll_factor == 6'h28)
    else $error("usb pll factor wrong");
  a_dev_gate: assert property (usb_dev_clock_tick |-> $past(usb_pll_tick))
    else $error("device clock without usb pll tick");
  a_host_gate: assert property (usb_host_clock_tick |-> $past(usb_pll_tick))
    else $error("host clock without usb pll tick");
endmodule

bind pmcc_top pmcc_checker u_chk (.ref_clk, .rst_b, .psel, .penable, .paddr, .pready, .pslverr,
  .system_pll_tick, .usb_pll_tick, .system_pll_input_ratio, .system_pll_multiplier,
  .system_pll_enable, .usb_pll_factor, .system_pll_out, .usb_dev_clock_tick,
  .usb_host_clock_tick);

/* File: verification/pmcc_sources.sv */
/*
  Model of the clock sources feeding the block, as one-cycle ticks.
  Assumes one reference clock; every tick period divides the bench windows.
*/
`timescale 1ns/100ps

module pmcc_sources (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  output logic      low_freq_tick,
  output logic      base_osc_tick,
  output logic      system_pll_tick,
  output logic      usb_pll_tick
);
  logic [3:0] phase_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

  // Periods of 16, 4, 2 and 2 cycles; the PLL ticks stand for the analog macros.
  assign low_freq_tick   = rst_b && (phase_q == 4'hF);
  assign base_osc_tick   = rst_b && (phase_q[1:0] == 2'h3);
  assign system_pll_tick = rst_b && phase_q[0];
  assign usb_pll_tick    = rst_b && !phase_q[0];
endmodule

/* File: verification/pmcc_bench.sv */
/*
  Self-checking bench for the clock control block: APB tasks, pulse
  counters over fixed windows, and checks on status and gating.
  Assumes the pmcc_top ports and the source model pmcc_sources.
*/
`timescale 1ns/100ps

module pmcc_bench;
  logic        ref_clk, rst_b, psel, penable, pwrite, instr_done, wake_irq, clr;
  logic        pready, pslverr, low_t, base_t, spll_t, upll_t, spll_en, upll_en, clock_irq, e_r;
  logic [7:0]  paddr, ratio_o, outs;
  logic [10:0] mul_o;
  logic [5:0]  factor_o;
  logic [31:0] pwdata, prdata, q_r;
  int          cnt [8];
  int          checks, mismatches, n;
  int          sp [4] = '{16, 4, 2, 2};
  int          dv [8] = '{1, 2, 4, 8, 16, 32, 64, 6};

  pmcc_top dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .low_freq_tick(low_t), .base_osc_tick(base_t), .system_pll_tick(spll_t),
    .usb_pll_tick(upll_t), .instr_done, .wake_irq, .system_pll_input_ratio(ratio_o),
    .system_pll_multiplier(mul_o), .system_pll_enable(spll_en), .usb_pll_enable(upll_en),
    .usb_pll_factor(factor_o), .system_pll_out(outs[0]), .cpu_clock_tick(outs[1]),
    .bus_clock(outs[2]), .ddr_clock_tick(outs[3]), .usb_dev_clock_tick(outs[4]),
    .usb_host_clock_tick(outs[5]), .ohci_48m_clock(outs[6]), .ohci_12m_clock(outs[7]),
    .clock_irq);
  pmcc_sources src (.ref_clk, .rst_b, .low_freq_tick(low_t), .base_osc_tick(base_t),
    .system_pll_tick(spll_t), .usb_pll_tick(upll_t));

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Pulse counters, cleared at the start of each window
  always @(posedge ref_clk) begin
    for (int i = 0; i < 8; i++) cnt[i] <= clr ? 0 : cnt[i] + ((outs[i] === 1'h1) ? 1 : 0);
  end

  // ==========================================================================
  // Tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    mismatches++;
    $display("MISMATCH %0t %s", $time, m);
    end_sim();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Starts on a rising edge; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'h1 && k < 16);
    if (pready !== 1'h1) fail("no ready");
    q_r = prdata;
    e_r = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(q_r, e);
  endtask

  task automatic poll(input int b, input int lim);
    n = 0;
    do begin
      apb(1'h0, 8'h68, 32'h0);
      n++;
    end while (q_r[b] !== 1'h1 && n < lim);
    if (q_r[b] !== 1'h1) fail("flag wait");
  endtask

  // One field of the master configuration at a time, then wait for the switch.
  // The cleared flag is seen through the masked interrupt one cycle after the
  // write, since a status read comes too late to miss a fast new bus tick.
  task automatic setmc(input logic [31:0] v);
    wr(8'h30, v);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(clock_irq, 1'h0);
    poll(3, 300);
  endtask

  task automatic meas(input int w);
    repeat (200) @(posedge ref_clk);
    clr <= 1'h1;
    @(posedge ref_clk);
    clr <= 1'h0;
    repeat (w) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, instr_done, wake_irq, clr} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    checks = 0;
    mismatches = 0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    rd(8'h08, 32'h1);
    rd(8'h30, 32'h1);
    rd(8'h68, 32'h8);
    meas(1536);
    for (int i = 3; i < 8; i++) chk(cnt[i], 0);
    apb(1'h0, 8'h0C, 32'h0);
    chk(e_r, 1'h1);
    chk(q_r, 32'h0);
    wr(8'h28, 32'h0005_0300);
    meas(1536);
    chk(cnt[0], 0);
    wr(8'h28, 32'h0005_0301);
    poll(1, 100);
    chk(n >= 15, 1'h1);
    chk({ratio_o, mul_o, spll_en}, {8'h01, 11'h005, 1'h1});
    meas(1536);
    chk(cnt[0], 768);
    wr(8'h6C, 32'h2);
    setmc(32'h1001);
    meas(1536);
    chk(cnt[0], 384);
    setmc(32'h1);
    wr(8'h28, 32'h0005_03FF);
    @(negedge ref_clk);
    chk(ratio_o, 8'hFF);
    wr(8'h28, 32'h0000_03FF);
    rd(8'h68, 32'h8);
    chk(spll_en, 1'h0);
    wr(8'h28, 32'h0005_0001);
    wr(8'h1C, 32'h0001_0000);
    for (int s = 0; s < 4; s++) begin
      setmc(s);
      meas(1536);
      chk(cnt[1], 1536 / sp[s]);
    end
    for (int k = 0; k < 8; k++) begin
      setmc(32'h1 | (k << 4));
      meas(1536);
      chk(cnt[1], 1536 / (4 * dv[k]));
    end
    setmc(32'h1);
    wr(8'h00, 32'h4);
    rd(8'h08, 32'h5);
    meas(1536);
    chk(cnt[3], 0);
    for (int r = 1; r < 4; r++) begin
      setmc(32'h1 | (r << 8));
      meas(1536);
      chk(cnt[2], 1536 / (4 * (r + 1)));
      chk({cnt[1], cnt[3]}, {32'd384, 32'd384});
    end
    wr(8'h04, 32'h4);
    setmc(32'h1);
    wr(8'h10, 32'h00C0_0000);
    rd(8'h18, 32'h00C0_0000);
    meas(1536);
    chk({cnt[4], cnt[5]}, {32'd768, 32'd768});
    wr(8'h14, 32'h0080_0000);
    meas(1536);
    chk({cnt[4], cnt[5]}, {32'd0, 32'd768});
    rd(8'h18, 32'h0040_0000);
    wr(8'h00, 32'h40);
    for (int u = 0; u < 2; u++) begin
      wr(8'h38, 32'h900 | u);
      meas(3840);
      chk({cnt[6], cnt[7]}, {32'd192, 32'd48});
    end
    wr(8'h04, 32'h40);
    rd(8'h08, 32'h1);
    meas(1536);
    chk(cnt[6], 0);
    wr(8'h1C, 32'h0021_0000);
    poll(6, 400);
    chk({n >= 43, upll_en}, 2'h3);
    wr(8'h68, 32'h0);
    rd(8'h68, 32'h4A);
    for (int m = 0; m < 4; m++) begin
      wr(8'h6C, (m < 3) ? (1 << m) : 0);
      rd(8'h6C, (m < 3) ? (1 << m) : 0);
      @(negedge ref_clk);
      chk(clock_irq, m < 3);
    end
    wr(8'h04, 32'h1);
    rd(8'h08, 32'h1);
    meas(1536);
    chk(cnt[1], 384);
    @(posedge ref_clk);
    instr_done <= 1'h1;
    @(posedge ref_clk);
    instr_done <= 1'h0;
    meas(1536);
    chk({cnt[1], cnt[2]}, {32'd0, 32'd384});
    rd(8'h08, 32'h0);
    @(posedge ref_clk);
    wake_irq <= 1'h1;
    @(posedge ref_clk);
    wake_irq <= 1'h0;
    meas(1536);
    chk(cnt[1], 384);
    rd(8'h08, 32'h1);
    end_sim();
  end
endmodule
